// *** hw/flash_sel_pkg.sv ***
// Package with register map, field layout and bus carrier of the flash select block
`default_nettype none
package flash_sel_pkg;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned MODE_W = 3;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [ADDR_W-1:0] OFF_CONTROL_ONE = 8'h40;
	localparam logic [ADDR_W-1:0] OFF_LARGE_SEL   = 8'h41;
	localparam logic [ADDR_W-1:0] OFF_ERASE_SEL   = 8'h42;
	localparam logic [ADDR_W-1:0] OFF_ERR_STATUS  = 8'h43;

	// ****************************************
	// Values and fields
	// ****************************************
	localparam logic [DATA_W-1:0] SEL_RESET_VAL  = 8'h00;
	localparam logic [DATA_W-1:0] LOCKED_READ    = 8'hFF;
	localparam logic [DATA_W-1:0] UNMAPPED_READ  = 8'h00;
	localparam logic [DATA_W-1:0] STATUS_RESET   = 8'h00;
	localparam int unsigned       ERR_FLAG_BIT   = 7;
	localparam int unsigned       RSVD_HI_BIT    = 6;
	localparam int unsigned       RSVD_LO_BIT    = 0;
	localparam logic [MODE_W-1:0] MODE_FIRST_ON  = 3'h5;
	localparam logic [MODE_W-1:0] MODE_FIRST_OFF = 3'h1;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bus_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] control_one;
		logic [DATA_W-1:0] large_sel;
		logic [DATA_W-1:0] erase_sel;
	} sel_out_t;
endpackage : flash_sel_pkg
`default_nettype wire

// *** hw/sel_byte_reg.sv ***
// Lockable software select register with fixed reset value
`default_nettype none
module sel_byte_reg #(
	parameter int unsigned     WIDTH     = 8,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             clk,    // System clock
	input  wire logic             rst,    // Asynchronous reset, active high
	input  wire logic             wr_en,  // Write strobe for this register
	input  wire logic             lock,   // Flash disabled, writes dropped
	input  wire logic [WIDTH-1:0] wdata,  // Write data
	output logic      [WIDTH-1:0] q       // Stored value
);
	if (WIDTH < 1) begin : g_width_bad
		$error("sel_byte_reg WIDTH must be at least 1");
	end

	// Locked writes are taken on the bus but leave the contents alone
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= RESET_VAL; // RL4
		end else if (wr_en && !lock) begin
			q <= wdata; // RL6
		end
	end
endmodule : sel_byte_reg
`default_nettype wire

// *** hw/flash_block_select_regs.sv ***
// Flash block select, control and error status registers on a plain register port
// ****************************************
// Behaviour
// [RL1] Erase select byte: one makes a block erasable, zero keeps it protected.
// [RL2] Large-block select byte: set bit selects that large block.
// [RL3] Modes 1 to 4: select registers ignore writes and read all ones.
// [RL4] Modes 5 to 7: select registers reset to zero, read and write freely.
// [RL5] Error status bits six to zero keep written values and read back.
// [RL6] Locked writes finish normally on the bus and change nothing.
// ****************************************
//
// Chosen here: the plain strobed port.
`default_nettype none
module flash_block_select_regs
	import flash_sel_pkg::*;
(
	input  wire logic              clk,         // System clock, 100 MHz
	input  wire logic              rst,         // Asynchronous reset, active high
	input  wire bus_req_t          bus_req,     // Register port request
	input  wire logic [MODE_W-1:0] mode_pins,   // Operating mode pins, asynchronous
	input  wire logic              flash_fault, // Error protection event, one cycle
	output logic      [DATA_W-1:0] rd_data_q,   // Read data, cycle after read strobe
	output var sel_out_t           sel_q,       // Select and control contents
	output logic                   locked_q,    // Flash disabled by mode
	output logic                   err_flag_q   // Error protection flag
);
	if (DATA_W != 8) begin : g_data_bad
		$error("flash_block_select_regs needs byte data");
	end

	// ****************************************
	// Decode helpers
	// ****************************************
	function automatic logic is_sel_addr(input logic [ADDR_W-1:0] a);
		return (a == OFF_CONTROL_ONE) || (a == OFF_LARGE_SEL) || (a == OFF_ERASE_SEL);
	endfunction : is_sel_addr

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return is_sel_addr(a) || (a == OFF_ERR_STATUS);
	endfunction : is_mapped

	// ****************************************
	// Mode pin synchroniser and lock
	// ****************************************
	logic [MODE_W-1:0] mode_meta_q;
	logic [MODE_W-1:0] mode_sync_q;

	// Sync flops reset to a locked mode so the lock cannot drop before the pins are seen
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_meta_q <= MODE_FIRST_OFF;
			mode_sync_q <= MODE_FIRST_OFF;
		end else begin
			mode_meta_q <= mode_pins;
			mode_sync_q <= mode_meta_q;
		end
	end

	// Lock starts set so no write slips in before the mode is known
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			locked_q <= 1'b1;
		end else begin
			locked_q <= (mode_sync_q >= MODE_FIRST_OFF) && (mode_sync_q < MODE_FIRST_ON); // RL3
		end
	end

	// ****************************************
	// Select registers
	// ****************************************
	logic ctrl_wr;
	logic large_wr;
	logic erase_wr;

	// Decoded once so the registers and the further select and lock checks below share one view of the strobe
	assign ctrl_wr  = bus_req.wr && (bus_req.addr == OFF_CONTROL_ONE);
	assign large_wr = bus_req.wr && (bus_req.addr == OFF_LARGE_SEL);
	assign erase_wr = bus_req.wr && (bus_req.addr == OFF_ERASE_SEL);

	sel_byte_reg #(.WIDTH(DATA_W), .RESET_VAL(SEL_RESET_VAL)) u_control_one (
		.clk   (clk),
		.rst   (rst),
		.wr_en (ctrl_wr),
		.lock  (locked_q),
		.wdata (bus_req.wdata),
		.q     (sel_q.control_one)
	);

	sel_byte_reg #(.WIDTH(DATA_W), .RESET_VAL(SEL_RESET_VAL)) u_large_sel (
		.clk   (clk),
		.rst   (rst),
		.wr_en (large_wr), // RL2
		.lock  (locked_q),
		.wdata (bus_req.wdata),
		.q     (sel_q.large_sel)
	);

	sel_byte_reg #(.WIDTH(DATA_W), .RESET_VAL(SEL_RESET_VAL)) u_erase_sel (
		.clk   (clk),
		.rst   (rst),
		.wr_en (erase_wr), // RL1
		.lock  (locked_q),
		.wdata (bus_req.wdata),
		.q     (sel_q.erase_sel)
	);

	// ****************************************
	// Error status register
	// ****************************************
	logic [RSVD_HI_BIT:RSVD_LO_BIT] rsvd_q;
	logic                           st_wr;

	assign st_wr = bus_req.wr && (bus_req.addr == OFF_ERR_STATUS);

	// Reserved bits only store and read back; no other logic looks at them
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rsvd_q <= STATUS_RESET[RSVD_HI_BIT:RSVD_LO_BIT];
		end else if (st_wr) begin
			rsvd_q <= bus_req.wdata[RSVD_HI_BIT:RSVD_LO_BIT]; // RL5
		end
	end

	// A fault in the clearing cycle still sets the flag
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			err_flag_q <= STATUS_RESET[ERR_FLAG_BIT];
		end else if (flash_fault) begin
			err_flag_q <= 1'b1;
		end else if (st_wr) begin
			err_flag_q <= bus_req.wdata[ERR_FLAG_BIT];
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	logic [DATA_W-1:0] rd_mux;

	always_comb begin
		rd_mux = UNMAPPED_READ;
		if (is_sel_addr(bus_req.addr) && locked_q) begin
			rd_mux = LOCKED_READ; // RL3
		end else begin
			case (bus_req.addr)
				OFF_CONTROL_ONE: rd_mux = sel_q.control_one;
				OFF_LARGE_SEL:   rd_mux = sel_q.large_sel; // RL2
				OFF_ERASE_SEL:   rd_mux = sel_q.erase_sel; // RL4
				OFF_ERR_STATUS:  rd_mux = {err_flag_q, rsvd_q}; // RL5
				default:         rd_mux = UNMAPPED_READ;
			endcase
		end
	end

	// Data is valid only in the cycle after the strobe, zero otherwise
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data_q <= UNMAPPED_READ;
		end else if (bus_req.rd) begin
			rd_data_q <= rd_mux;
		end else begin
			rd_data_q <= UNMAPPED_READ;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence locked_sel_rd_s;
		bus_req.rd && locked_q && is_sel_addr(bus_req.addr);
	endsequence

	sequence open_erase_wr_s;
		bus_req.wr && !locked_q && (bus_req.addr == OFF_ERASE_SEL);
	endsequence

	sequence locked_erase_wr_s;
		bus_req.wr && locked_q && (bus_req.addr == OFF_ERASE_SEL);
	endsequence

	sequence open_large_wr_s;
		large_wr && !locked_q;
	endsequence

	sequence locked_large_wr_s;
		large_wr && locked_q;
	endsequence

	sequence open_ctrl_wr_s;
		ctrl_wr && !locked_q;
	endsequence

	sequence locked_ctrl_wr_s;
		ctrl_wr && locked_q;
	endsequence

	sequence off_mode_s;
		(mode_sync_q >= MODE_FIRST_OFF) && (mode_sync_q < MODE_FIRST_ON);
	endsequence

	sequence status_rd_s;
		bus_req.rd && (bus_req.addr == OFF_ERR_STATUS);
	endsequence

	locked_read_ones_a: assert property (locked_sel_rd_s |=> rd_data_q == LOCKED_READ) // RL3
		else $error("locked select read did not return all ones");

	locked_write_hold_a: assert property (locked_erase_wr_s |=> $stable(sel_q.erase_sel)) // RL6
		else $error("locked write changed erase select");

	erase_write_a: assert property (open_erase_wr_s |=> sel_q.erase_sel == $past(bus_req.wdata)) // RL1
		else $error("erase select did not take write");

	large_write_a: assert property (bus_req.wr && !locked_q && (bus_req.addr == OFF_LARGE_SEL)
		|=> sel_q.large_sel == $past(bus_req.wdata)) // RL2
		else $error("large select did not take write");

	open_read_a: assert property (bus_req.rd && !locked_q && (bus_req.addr == OFF_ERASE_SEL)
		|=> rd_data_q == $past(sel_q.erase_sel)) // RL4
		else $error("open erase select read mismatch");

	reserved_keep_a: assert property (st_wr ##1 (!st_wr)[*2]
		|-> rsvd_q == $past(bus_req.wdata[RSVD_HI_BIT:RSVD_LO_BIT], 2)) // RL5
		else $error("reserved status bits lost written value");

	fault_wins_a: assert property (flash_fault |=> err_flag_q) // RL5
		else $error("error flag not set after fault");

	unmapped_zero_a: assert property (bus_req.rd && !is_mapped(bus_req.addr) |=> rd_data_q == UNMAPPED_READ) // RL6
		else $error("unmapped read not zero");

	rd_only_after_a: assert property (!bus_req.rd |=> rd_data_q == UNMAPPED_READ) // RL4
		else $error("read data outside read cycle");

	// ****************************************
	// Further select and lock checks
	// ****************************************
	ctrl_write_a: assert property (open_ctrl_wr_s |=> sel_q.control_one == $past(bus_req.wdata)) // RL4
		else $error("control register did not take write");

	locked_large_hold_a: assert property (locked_large_wr_s |=> $stable(sel_q.large_sel)) // RL6
		else $error("locked write changed large select");

	locked_ctrl_hold_a: assert property (locked_ctrl_wr_s |=> $stable(sel_q.control_one)) // RL6
		else $error("locked write changed control register");

	// Contents must not drift when nobody writes them
	erase_idle_hold_a: assert property (!erase_wr |=> $stable(sel_q.erase_sel)) // RL1
		else $error("erase select changed without a write");

	large_idle_hold_a: assert property (!large_wr |=> $stable(sel_q.large_sel)) // RL2
		else $error("large select changed without a write");

	large_read_a: assert property (bus_req.rd && !locked_q && (bus_req.addr == OFF_LARGE_SEL)
		|=> rd_data_q == $past(sel_q.large_sel)) // RL2
		else $error("open large select read mismatch");

	ctrl_read_a: assert property (bus_req.rd && !locked_q && (bus_req.addr == OFF_CONTROL_ONE)
		|=> rd_data_q == $past(sel_q.control_one)) // RL4
		else $error("open control register read mismatch");

	lock_follow_a: assert property (off_mode_s |=> locked_q) // RL3
		else $error("lock missing in flash disabled mode");

	unlock_follow_a: assert property (!((mode_sync_q >= MODE_FIRST_OFF) && (mode_sync_q < MODE_FIRST_ON))
		|=> !locked_q) // RL4
		else $error("lock held in flash enabled mode");

	// ****************************************
	// Status register checks
	// ****************************************
	rsvd_idle_hold_a: assert property (!st_wr |=> $stable(rsvd_q)) // RL5
		else $error("reserved status bits changed without a write");

	flag_clear_a: assert property (st_wr && !flash_fault && !bus_req.wdata[ERR_FLAG_BIT] |=> !err_flag_q) // RL5
		else $error("error flag not cleared by write");

	flag_set_wr_a: assert property (st_wr && bus_req.wdata[ERR_FLAG_BIT] |=> err_flag_q) // RL5
		else $error("error flag not set by write");

	flag_hold_a: assert property (!st_wr && !flash_fault |=> $stable(err_flag_q)) // RL5
		else $error("error flag changed on its own");

	status_read_a: assert property (status_rd_s |=> rd_data_q == {$past(err_flag_q), $past(rsvd_q)}) // RL5
		else $error("status read mismatch");
endmodule : flash_block_select_regs
`default_nettype wire

// *** verif/flash_block_select_regs_tb.sv ***
// Self-checking bench for the flash select register block
`default_nettype none
module flash_block_select_regs_tb
	import flash_sel_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Signals and design
	// ****************************************
	logic              clk;
	logic              rst;
	bus_req_t          req;
	logic [MODE_W-1:0] mode_pins;
	logic              flash_fault;
	logic [DATA_W-1:0] rd_data_q;
	sel_out_t          sel_q;
	logic              locked_q;
	logic              err_flag_q;
	int                bad_count;
	int                num_checks;

	flash_block_select_regs i_dut (
		.clk        (clk),
		.rst        (rst),
		.bus_req    (req),
		.mode_pins  (mode_pins),
		.flash_fault(flash_fault),
		.rd_data_q  (rd_data_q),
		.sel_q      (sel_q),
		.locked_q   (locked_q),
		.err_flag_q (err_flag_q)
	);

	always #5 clk = ~clk;

	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		num_checks++;
		if (seen !== want) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check

	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] v);
		@(posedge clk);
		req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk);
		req <= '0;
		#1 v = rd_data_q;
	endtask : bus

	// Mode pins pass two sync flops, so the lock flag lags by a few edges
	task automatic set_mode(input logic [2:0] m, input logic want);
		@(posedge clk);
		mode_pins <= m;
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			#1;
			if (locked_q === want) begin
				check({7'h00, locked_q}, {7'h00, want});
				return;
			end
		end
		bad_count++;
		give_verdict();
	endtask : set_mode

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [7:0] d;
		logic [7:0] v;
		logic [7:0] exp_q [3];
		clk = 1'b0;
		rst = 1'b1;
		req = '0;
		mode_pins = 3'h5;
		flash_fault = 1'b0;
		bad_count = 0;
		num_checks = 0;
		void'($urandom(47));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		set_mode(3'h5, 1'b0);
		for (int a = 0; a < 4; a++) begin
			bus(1'b0, OFF_CONTROL_ONE + a, 8'h00, v);
			check(v, SEL_RESET_VAL);
		end
		for (int m = 5; m < 8; m++) begin
			set_mode(m, 1'b0);
			for (int a = 0; a < 3; a++) begin
				d = (m == 5) ? 8'hFF : $urandom;
				exp_q[a] = d;
				bus(1'b1, OFF_CONTROL_ONE + a, d, v);
			end
			for (int a = 0; a < 3; a++) begin
				bus(1'b0, OFF_CONTROL_ONE + a, 8'h00, v);
				check(v, exp_q[a]);
			end
			check(sel_q.large_sel, exp_q[1]);
			check(sel_q.erase_sel, exp_q[2]);
			d = $urandom;
			bus(1'b1, OFF_ERR_STATUS, d & 8'h7F, v);
			bus(1'b0, OFF_ERR_STATUS, 8'h00, v);
			check(v, d & 8'h7F);
		end
		// A fault must leave the reserved status bits as written
		@(posedge clk);
		flash_fault <= 1'b1;
		@(posedge clk);
		flash_fault <= 1'b0;
		bus(1'b0, OFF_ERR_STATUS, 8'h00, v);
		check(v, 8'h80 | (d & 8'h7F));
		check({7'h00, err_flag_q}, 8'h01);
		// Fault beside a clearing write: the fault must win
		@(posedge clk);
		flash_fault <= 1'b1;
		req <= '{wr: 1'b1, rd: 1'b0, addr: OFF_ERR_STATUS, wdata: 8'h00};
		@(posedge clk);
		flash_fault <= 1'b0;
		req <= '0;
		#1 check({7'h00, err_flag_q}, 8'h01);
		bus(1'b1, OFF_ERR_STATUS, 8'h00, v);
		check({7'h00, err_flag_q}, 8'h00);
		bus(1'b0, 8'h44, 8'h00, v);
		check(v, UNMAPPED_READ);
		for (int m = 1; m < 5; m++) begin
			set_mode(m, 1'b1);
			for (int a = 0; a < 3; a++) begin
				bus(1'b1, OFF_CONTROL_ONE + a, ~exp_q[a], v);
				bus(1'b0, OFF_CONTROL_ONE + a, 8'h00, v);
				check(v, LOCKED_READ);
			end
			check(sel_q.control_one, exp_q[0]);
			check(sel_q.large_sel, exp_q[1]);
			check(sel_q.erase_sel, exp_q[2]);
		end
		set_mode(3'h5, 1'b0);
		bus(1'b0, OFF_ERASE_SEL, 8'h00, v);
		check(v, exp_q[2]);
		give_verdict();
	end
endmodule : flash_block_select_regs_tb
`default_nettype wire
